// *** inc/uar_params.svh ***
/*
 * offsets, field positions, reset values and timing counts
 * of the serial receiver block.
 * assumes a 32-bit bus with one register per aligned word.
 */
`ifndef UAR_PARAMS_SVH
`define UAR_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define UAR_OFF_RXSC 8'h00
`define UAR_OFF_RXDATA 8'h04
`define UAR_OFF_BAUD 8'h08
`define UAR_OFF_TXSC 8'h0C
`define UAR_OFF_IRQEN 8'h10
`define UAR_OFF_IRQFLAG 8'h14

// ****************************************
// receive status and control fields
// ****************************************
`define UAR_RX_PORT_EN 7
`define UAR_RX_NINE 6
`define UAR_RX_SINGLE 5
`define UAR_RX_CONT 4
`define UAR_RX_ADDR 3
`define UAR_RX_FRAMING_ERROR_FLAG 2
`define UAR_RX_OVERRUN_ERROR_FLAG 1
`define UAR_RX_BIT9 0

// ****************************************
// transmit status and control fields
// ****************************************
`define UAR_TX_CLKSRC 7
`define UAR_TX_NINE 6
`define UAR_TX_EN 5
`define UAR_TX_SYNC 4
`define UAR_TX_SPEED 2
`define UAR_TX_EMPTY 1
`define UAR_TX_BIT9 0

// ****************************************
// reset values and timing
// ****************************************
`define UAR_RST_TXSC 8'h02
`define UAR_RST_TX_EMPTY 1'b1
`define UAR_RST_BYTE 8'h00
`define UAR_OVERSAMPLE 16
`define UAR_LOW_SPEED_MUL 4
`define UAR_SAMPLE_A 4'h7
`define UAR_SAMPLE_B 4'h8
`define UAR_SAMPLE_C 4'h9
`define UAR_BIT_LAST 4'hF

`endif

// *** inc/uar_pkg.sv ***
/*
 * types of the serial receiver block.
 * assumes uar_params.svh for the numbers.
 */
package uar_pkg;

    // receive queue entry
    typedef struct packed {
        logic framing_error_flag;
        logic bit9;
        logic [7:0] data;
    } uar_entry_s;

    // receive status and control, writable part
    typedef struct packed {
        logic port_enable;
        logic nine_bit_receive_select;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic address_detect_enable;
    } uar_rxctl_s;

    // transmit status and control
    typedef struct packed {
        logic clock_source_select;
        logic nine_bit_transmit_select;
        logic transmit_enable;
        logic mode_sync;
        logic speed_select;
        logic transmit_ninth_bit;
    } uar_txctl_s;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } uar_rx_st_e;

endpackage

// *** src/uar_rx.sv ***
/*
 * asynchronous serial receiver with two-entry queue, framing
 * and overrun flags, nine-bit reception and address detection,
 * plus the transmit status/control register, on an ahb-lite slave.
 * assumes a single 10 MHz hclk, the receive pin from outside the
 * clock domain, and the transmit datapath reporting its shift
 * register state on the same clock.
 */
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "uar_params.svh"

module uar_rx
    import uar_pkg::*;
#(
    parameter int QDEPTH = 2
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // serial line and transmitter status
    input wire logic rx_pin,
    input wire logic tx_shift_full,
    // to the rest of the chip
    output logic rx_irq_req,
    output logic receive_flag,
    output uar_txctl_s tx_ctl,
    output logic tx_master_clock,
    output logic tx_active
);

    // ****************************************
    // registers
    // ****************************************
    uar_rxctl_s rxctl_r;
    uar_txctl_s txctl_r;
    logic [7:0] baud_r;
    logic irq_en_r;
    logic empty_r;
    logic [7:0] wr_addr_r;
    logic wr_pend_r;
    logic [7:0] rd_addr_r;
    logic rd_pend_r;
    logic [31:0] hrdata_r;
    logic hready_r;

    logic [7:0] brg_cnt_r;
    logic [1:0] pre_cnt_r;
    logic tick_r;
    logic rx_s1_r;
    logic rx_s2_r;

    uar_rx_st_e st_r;
    logic [3:0] os_r;
    logic [3:0] bit_r;
    logic [8:0] sh_r;
    logic samp_a_r;
    logic samp_b_r;

    uar_entry_s q_r [QDEPTH];
    logic head_r;
    logic [1:0] cnt_r;
    logic overrun_error_flag_r;
    logic irq_r;
    logic flag_r;

    logic accept;
    logic baud_wr;
    logic rxsc_wr;
    logic pop;
    logic maj;
    logic done;
    logic rx_run;
    logic keep;
    logic push;
    logic wr_idx;
    uar_entry_s head_e;
    uar_entry_s new_e;
    logic [7:0] rd_mux;

    // ****************************************
    // bus decode
    // ****************************************
    assign accept = hsel & htrans[1] & hready;
    assign baud_wr = wr_pend_r & (wr_addr_r == `UAR_OFF_BAUD);
    assign rxsc_wr = wr_pend_r & (wr_addr_r == `UAR_OFF_RXSC);
    assign pop = rd_pend_r & (rd_addr_r == `UAR_OFF_RXDATA) & (cnt_r != 2'd0);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rd_pend_r <= 1'b0;
            rd_addr_r <= 8'h00;
            hready_r <= 1'b1;
        end else begin
            // reads take one wait state so that a write just before them is seen
            wr_pend_r <= accept & hwrite;
            rd_pend_r <= accept & ~hwrite;
            hready_r <= ~(accept & ~hwrite);
            if (accept) begin
                wr_addr_r <= {haddr[7:2], 2'b00};
                rd_addr_r <= {haddr[7:2], 2'b00};
            end
        end
    end

    assign head_e = q_r[head_r];

    always_comb begin
        rd_mux = 8'h00;
        unique case (rd_addr_r)
            `UAR_OFF_RXSC: rd_mux = {rxctl_r, head_e.framing_error_flag, overrun_error_flag_r, head_e.bit9};
            `UAR_OFF_RXDATA: rd_mux = head_e.data;
            `UAR_OFF_BAUD: rd_mux = baud_r;
            `UAR_OFF_TXSC: rd_mux = {txctl_r.clock_source_select, txctl_r.nine_bit_transmit_select,
                                      txctl_r.transmit_enable, txctl_r.mode_sync, 1'b0,
                                      txctl_r.speed_select, empty_r, txctl_r.transmit_ninth_bit};
            `UAR_OFF_IRQEN: rd_mux = {7'h00, irq_en_r};
            `UAR_OFF_IRQFLAG: rd_mux = {7'h00, flag_r};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_pend_r) begin
            hrdata_r <= {24'h00_0000, rd_mux};
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hready_r;
    assign hresp = 1'b0;

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rxctl_r <= '0;
        end else if (rxsc_wr) begin
            rxctl_r <= hwdata[7:3];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txctl_r <= '0;
        end else if (wr_pend_r && wr_addr_r == `UAR_OFF_TXSC) begin
            txctl_r.clock_source_select <= hwdata[`UAR_TX_CLKSRC];
            txctl_r.nine_bit_transmit_select <= hwdata[`UAR_TX_NINE];
            txctl_r.transmit_enable <= hwdata[`UAR_TX_EN];
            txctl_r.mode_sync <= hwdata[`UAR_TX_SYNC];
            txctl_r.speed_select <= hwdata[`UAR_TX_SPEED];
            txctl_r.transmit_ninth_bit <= hwdata[`UAR_TX_BIT9];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            baud_r <= `UAR_RST_BYTE;
            irq_en_r <= 1'b0;
        end else if (wr_pend_r) begin
            if (wr_addr_r == `UAR_OFF_BAUD) begin
                baud_r <= hwdata[7:0];
            end
            if (wr_addr_r == `UAR_OFF_IRQEN) begin
                irq_en_r <= hwdata[0];
            end
        end
    end

    // shift register status tracks the transmitter; empty from reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            empty_r <= `UAR_RST_TX_EMPTY;
        end else begin
            empty_r <= ~tx_shift_full;
        end
    end

    // clock source only matters in sync mode; receive overrides transmit there
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_master_clock <= 1'b0;
            tx_active <= 1'b0;
        end else begin
            tx_master_clock <= txctl_r.mode_sync & txctl_r.clock_source_select;
            tx_active <= rxctl_r.port_enable & txctl_r.transmit_enable
                         & ~(txctl_r.mode_sync & (rxctl_r.single_receive_enable
                         | rxctl_r.continuous_receive_enable));
        end
    end

    assign tx_ctl = txctl_r;

    // ****************************************
    // baud generator, 16x oversample tick
    // ****************************************
    // a write to the divisor restarts the count so the new rate shows at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            brg_cnt_r <= 8'h00;
            pre_cnt_r <= 2'b00;
            tick_r <= 1'b0;
        end else if (baud_wr || !rxctl_r.port_enable) begin
            brg_cnt_r <= 8'h00;
            pre_cnt_r <= 2'b00;
            tick_r <= 1'b0;
        end else if (brg_cnt_r == baud_r) begin
            brg_cnt_r <= 8'h00;
            pre_cnt_r <= pre_cnt_r + 2'b01;
            // low speed divides four times further; speed unused in sync mode
            tick_r <= ~txctl_r.mode_sync
                      & (txctl_r.speed_select | (pre_cnt_r == 2'(`UAR_LOW_SPEED_MUL - 1)));
        end else begin
            brg_cnt_r <= brg_cnt_r + 8'h01;
            tick_r <= 1'b0;
        end
    end

    // ****************************************
    // receive pin synchroniser
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end else begin
            rx_s1_r <= rx_pin;
            rx_s2_r <= rx_s1_r;
        end
    end

    // ****************************************
    // data recovery
    // ****************************************
    assign rx_run = rxctl_r.port_enable & rxctl_r.continuous_receive_enable
                    & ~txctl_r.mode_sync & ~overrun_error_flag_r;
    assign maj = (samp_a_r & samp_b_r) | (samp_a_r & rx_s2_r) | (samp_b_r & rx_s2_r);
    assign done = tick_r & (st_r == RX_STOP) & (os_r == `UAR_SAMPLE_C);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= RX_IDLE;
            os_r <= 4'h0;
            bit_r <= 4'h0;
            sh_r <= 9'h000;
            samp_a_r <= 1'b1;
            samp_b_r <= 1'b1;
        end else if (!rx_run) begin
            st_r <= RX_IDLE;
            os_r <= 4'h0;
        end else if (tick_r) begin
            os_r <= os_r + 4'h1;
            if (os_r == `UAR_SAMPLE_A) begin
                samp_a_r <= rx_s2_r;
            end
            if (os_r == `UAR_SAMPLE_B) begin
                samp_b_r <= rx_s2_r;
            end
            unique case (st_r)
                RX_IDLE: begin
                    os_r <= 4'h0;
                    if (!rx_s2_r) begin
                        st_r <= RX_START;
                    end
                end
                RX_START: begin
                    // false start: back to hunting, no error
                    if (os_r == `UAR_SAMPLE_A) begin
                        if (rx_s2_r) begin
                            st_r <= RX_IDLE;
                        end
                    end else if (os_r == `UAR_BIT_LAST) begin
                        st_r <= RX_DATA;
                        bit_r <= 4'h0;
                    end
                end
                RX_DATA: begin
                    if (os_r == `UAR_SAMPLE_C) begin
                        sh_r <= {maj, sh_r[8:1]};
                    end
                    if (os_r == `UAR_BIT_LAST) begin
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == (rxctl_r.nine_bit_receive_select ? 4'h8 : 4'h7)) begin
                            st_r <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (os_r == `UAR_SAMPLE_C) begin
                        st_r <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // receive queue
    // ****************************************
    always_comb begin
        new_e.framing_error_flag = ~maj;
        if (rxctl_r.nine_bit_receive_select) begin
            new_e.bit9 = sh_r[8];
            new_e.data = sh_r[7:0];
        end else begin
            new_e.bit9 = 1'b0;
            new_e.data = sh_r[8:1];
        end
    end

    // nine-bit address mode drops characters whose ninth bit is clear
    assign keep = ~(rxctl_r.address_detect_enable & rxctl_r.nine_bit_receive_select
                    & ~new_e.bit9);
    assign push = done & keep & ((cnt_r != 2'(QDEPTH)) | pop);
    assign wr_idx = head_r ^ cnt_r[0];

    generate
        for (genvar i = 0; i < QDEPTH; i++) begin : g_entry
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    q_r[i] <= '0;
                end else if (!rxctl_r.port_enable) begin
                    q_r[i] <= '0;
                end else if (push && wr_idx == 1'(i)) begin
                    q_r[i] <= new_e;
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            head_r <= 1'b0;
            cnt_r <= 2'd0;
        end else if (!rxctl_r.port_enable) begin
            head_r <= 1'b0;
            cnt_r <= 2'd0;
        end else begin
            if (pop) begin
                head_r <= ~head_r;
            end
            cnt_r <= cnt_r + 2'(push) - 2'(pop);
        end
    end

    // overrun: set on a whole third character, set wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overrun_error_flag_r <= 1'b0;
        end else if (done && keep && cnt_r == 2'(QDEPTH) && !pop) begin
            overrun_error_flag_r <= 1'b1;
        end else if (!rxctl_r.port_enable || !rxctl_r.continuous_receive_enable) begin
            overrun_error_flag_r <= 1'b0;
        end
    end

    // ****************************************
    // receive flag and interrupt request
    // ****************************************
    // queue occupancy drives these, the request also gated by the interrupt enable, never the framing flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            flag_r <= rxctl_r.port_enable & (cnt_r != 2'd0 || push) & !(cnt_r == 2'd1 && pop && !push);
            irq_r <= irq_en_r & rxctl_r.port_enable
                     & (cnt_r != 2'd0 || push) & !(cnt_r == 2'd1 && pop && !push);
        end
    end

    assign receive_flag = flag_r;
    assign rx_irq_req = irq_r;

endmodule // uar_rx

`default_nettype wire

// *** dv/uar_rx_assertions.sv ***
/*
 * checker for the serial receiver: bus timing, status bits, tx control outputs.
 * assumes binding onto uar_rx with a single hclk domain.
 */
`timescale 1ns/10ps
`default_nettype none
`include "uar_params.svh"

module uar_rx_assertions
    import uar_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // serial and chip side
    input wire logic rx_pin,
    input wire logic tx_shift_full,
    input wire logic rx_irq_req,
    input wire logic receive_flag,
    input wire uar_txctl_s tx_ctl,
    input wire logic tx_master_clock,
    input wire logic tx_active
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic mclk_ok;
    logic transmit_enable_now;
    assign mclk_ok = tx_ctl.mode_sync & tx_ctl.clock_source_select;
    assign transmit_enable_now = tx_ctl.transmit_enable;

    sequence rd_take;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence wr_take;
        hsel && htrans[1] && hready && hwrite;
    endsequence
    sequence txsc_take;
        rd_take ##0 ((haddr & 8'hFC) == `UAR_OFF_TXSC);
    endsequence

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("slave response not okay");
    a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read wait state not exactly one cycle");
    a_write_nowait: assert property (wr_take |=> hreadyout)
        else $error("write inserted a wait state");
    a_irq_needs_flag: assert property (rx_irq_req |-> receive_flag || $past(receive_flag))
        else $error("interrupt request without receive flag");
    a_txsc_hole_zero: assert property (txsc_take |-> ##2 (hrdata[3] == 1'b0 && hrdata[31:8] == 24'h00_0000))
        else $error("unimplemented tx control bit read non zero");
    a_shift_empty: assert property (((!tx_shift_full)[*3] ##0 txsc_take) ##1 !tx_shift_full |=> hrdata[1])
        else $error("shift empty status low while shift register empty");
    a_master_clk_src: assert property (tx_master_clock |-> mclk_ok || $past(mclk_ok))
        else $error("master clock without sync mode and internal source");
    a_tx_active_en: assert property (tx_active |-> transmit_enable_now || $past(transmit_enable_now))
        else $error("transmitter active while transmit disabled");
    a_rxflag_hold: assert property ((htrans == 2'b00)[*4] ##0 receive_flag |=> receive_flag)
        else $error("receive flag dropped without any bus access");
endmodule // uar_rx_assertions

bind uar_rx uar_rx_assertions u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .rx_pin, .tx_shift_full, .rx_irq_req, .receive_flag, .tx_ctl,
    .tx_master_clock, .tx_active);

`default_nettype wire

// *** dv/uar_ser_tx.sv ***
/*
 * behavioural far-end transmitter: one 8N1 or 9N1 frame per go, lsb first.
 * assumes the bench holds go until done, one bit lasting BIT_CLKS clocks.
 */
`timescale 1ns/10ps
`default_nettype none

module uar_ser_tx #(
    parameter int BIT_CLKS = 16
) (
    // clock
    input wire logic clk,
    // request from bench
    input wire logic go,
    input wire logic nine,
    input wire logic [8:0] dat,
    input wire logic bad_stop,
    // line and completion
    output logic line,
    output logic done
);
    logic [10:0] frm;
    int nb;

    initial begin
        line = 1'b1;
        done = 1'b0;
    end

    // ****************************************
    // framing
    // ****************************************
    always begin
        @(posedge clk);
        if (go && !done) begin
            frm = nine ? {!bad_stop, dat, 1'b0} : {1'b0, !bad_stop, dat[7:0], 1'b0};
            nb = nine ? 11 : 10;
            for (int i = 0; i < nb; i++) begin
                line <= frm[i];
                repeat (BIT_CLKS) @(posedge clk);
            end
            // one idle bit so a bad stop cannot run into the next start
            line <= 1'b1;
            repeat (BIT_CLKS) @(posedge clk);
            done <= 1'b1;
        end else if (!go) begin
            done <= 1'b0;
        end
    end
endmodule // uar_ser_tx

`default_nettype wire

// *** dv/uart_async_rx_error_addr_detect_tb_top.sv ***
/*
 * self-checking bench: ahb-lite register tasks plus a far-end transmitter.
 * assumes baud divisor 0 at high speed, so one bit is 16 hclk cycles.
 */
`timescale 1ns/10ps
`default_nettype none
`include "uar_params.svh"

module uart_async_rx_error_addr_detect_tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tx_shift_full = 1'b0;
    logic p_go = 1'b0, p_nine = 1'b0, p_bad = 1'b0;
    logic [8:0] p_dat = 9'h000;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    wire logic [31:0] hrdata;
    wire logic [5:0] tx_ctl;
    wire logic hreadyout, hresp, rx_pin, rx_irq_req, receive_flag, tx_master_clock, tx_active, p_done;
    int n_fail = 0, n_tests = 0;

    always #50 hclk = ~hclk;

    uar_rx uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .rx_pin, .tx_shift_full, .rx_irq_req, .receive_flag, .tx_ctl,
        .tx_master_clock, .tx_active);
    uar_ser_tx u_far (.clk(hclk), .go(p_go), .nine(p_nine), .dat(p_dat), .bad_stop(p_bad), .line(rx_pin),
        .done(p_done));

    // ****************************************
    // tasks
    // ****************************************
    task automatic give_verdict;
        $display("counts: %0d comparisons, %0d mismatches", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask

    task automatic hang(input string nm);
        $display("[FAIL] %s expected completion seen timeout", nm);
        n_fail++;
        give_verdict();
    endtask

    task automatic rdy;
        for (int i = 0; i < 40; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        hang("bus ready");
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        rdy();
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        rdy();
        q = hrdata[7:0];
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(nm, e, q);
    endtask

    task automatic idle(input int n);
        hsel <= 1'b0;
        repeat (n) @(posedge hclk);
    endtask

    task automatic send(input logic [8:0] d, input logic bad, input logic nine);
        int i;
        hsel <= 1'b0;
        p_dat <= d;
        p_bad <= bad;
        p_nine <= nine;
        p_go <= 1'b1;
        for (i = 0; i < 600; i++) begin
            @(posedge hclk);
            if (p_done === 1'b1) break;
        end
        if (i == 600) hang("frame");
        p_go <= 1'b0;
        @(posedge hclk);
    endtask

    // ****************************************
    // sequence of tests
    // ****************************************
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(`UAR_OFF_TXSC, 8'h02, "tx control reset");
        rc(`UAR_OFF_RXSC, 8'h00, "rx control reset");
        rc(`UAR_OFF_RXDATA, 8'h00, "rx data reset");
        rc(8'h1C, 8'h00, "unmapped read");
        wr(`UAR_OFF_BAUD, 8'hA5);
        rc(`UAR_OFF_BAUD, 8'hA5, "baud divisor");
        wr(`UAR_OFF_TXSC, 8'hFF);
        rc(`UAR_OFF_TXSC, 8'hF7, "tx control all ones");
        chk("tx ctl fields", 8'h3F, {2'b00, tx_ctl});
        chk("master clock sync", 8'h01, {7'h00, tx_master_clock});
        tx_shift_full <= 1'b1;
        idle(3);
        rc(`UAR_OFF_TXSC, 8'hF5, "shift full status");
        tx_shift_full <= 1'b0;
        wr(`UAR_OFF_RXSC, 8'h90);
        wr(`UAR_OFF_TXSC, 8'h30);
        idle(3);
        chk("tx active sync override", 8'h00, {7'h00, tx_active});
        chk("master clock external", 8'h00, {7'h00, tx_master_clock});
        wr(`UAR_OFF_TXSC, 8'hA4);
        idle(3);
        chk("tx active async", 8'h01, {7'h00, tx_active});
        chk("master clock async", 8'h00, {7'h00, tx_master_clock});
        $display("test tx control done");
        wr(`UAR_OFF_BAUD, 8'h00);
        wr(`UAR_OFF_RXSC, 8'h80);
        wr(`UAR_OFF_IRQEN, 8'h01);
        wr(`UAR_OFF_RXSC, 8'h90);
        send(9'h0A5, 1'b0, 1'b0);
        chk("receive flag set", 8'h01, {7'h00, receive_flag});
        chk("irq request set", 8'h01, {7'h00, rx_irq_req});
        rc(`UAR_OFF_IRQFLAG, 8'h01, "irq flag register");
        rc(`UAR_OFF_RXSC, 8'h90, "status good char");
        rc(`UAR_OFF_RXDATA, 8'hA5, "data good char");
        idle(3);
        chk("receive flag clear", 8'h00, {7'h00, receive_flag});
        $display("test basic receive done");
        send(9'h03C, 1'b1, 1'b0);
        send(9'h05A, 1'b1, 1'b0);
        rc(`UAR_OFF_RXSC, 8'h94, "framing first");
        rc(`UAR_OFF_RXDATA, 8'h3C, "framing data one");
        rc(`UAR_OFF_RXSC, 8'h94, "framing second");
        rc(`UAR_OFF_RXDATA, 8'h5A, "framing data two");
        send(9'h011, 1'b0, 1'b0);
        rc(`UAR_OFF_RXSC, 8'h90, "framing after good");
        rc(`UAR_OFF_RXDATA, 8'h11, "data after framing");
        $display("test framing done");
        send(9'h001, 1'b0, 1'b0);
        send(9'h002, 1'b0, 1'b0);
        send(9'h003, 1'b0, 1'b0);
        rc(`UAR_OFF_RXSC, 8'h92, "overrun set");
        send(9'h004, 1'b0, 1'b0);
        rc(`UAR_OFF_RXDATA, 8'h01, "overrun head");
        rc(`UAR_OFF_RXDATA, 8'h02, "overrun second");
        idle(3);
        chk("overrun blocks", 8'h00, {7'h00, receive_flag});
        wr(`UAR_OFF_RXSC, 8'h80);
        rc(`UAR_OFF_RXSC, 8'h80, "overrun cleared");
        $display("test overrun done");
        wr(`UAR_OFF_RXSC, 8'h90);
        send(9'h077, 1'b1, 1'b0);
        wr(`UAR_OFF_RXSC, 8'h80);
        rc(`UAR_OFF_RXSC, 8'h84, "framing kept");
        chk("flag kept", 8'h01, {7'h00, receive_flag});
        wr(`UAR_OFF_RXSC, 8'h00);
        rc(`UAR_OFF_RXSC, 8'h00, "port disable clears");
        chk("flag after disable", 8'h00, {7'h00, receive_flag});
        $display("test port reset done");
        wr(`UAR_OFF_RXSC, 8'hD0);
        send(9'h1AB, 1'b0, 1'b1);
        rc(`UAR_OFF_RXSC, 8'hD1, "ninth bit status");
        rc(`UAR_OFF_RXDATA, 8'hAB, "nine bit data");
        wr(`UAR_OFF_RXSC, 8'hD8);
        send(9'h0CC, 1'b0, 1'b1);
        send(9'h155, 1'b0, 1'b1);
        rc(`UAR_OFF_RXSC, 8'hD9, "address status");
        rc(`UAR_OFF_RXDATA, 8'h55, "address data");
        idle(3);
        chk("data char dropped", 8'h00, {7'h00, receive_flag});
        wr(`UAR_OFF_RXSC, 8'hD0);
        send(9'h0CC, 1'b0, 1'b1);
        rc(`UAR_OFF_RXSC, 8'hD0, "message status");
        rc(`UAR_OFF_RXDATA, 8'hCC, "message data");
        $display("test address detect done");
        give_verdict();
    end
endmodule // uart_async_rx_error_addr_detect_tb_top

`default_nettype wire
